// >>> rtl/dsol_top.sv
// Notes on behaviour
// - Open-collector sense resets to normally open
// - Separate sense bit for every open-collector and relay output
// - Normally closed inverts the active function
// - Fault reset input never inverted
// - Code zero routes running indication
// - Running active in operating mode and during DC braking
// - Running stays on during DC braking
// - Arrival codes 1, 2, 6, 19, 20
// - Constant speed: output reached commanded frequency
// - Over-frequency 1: on accelerating, off decelerating
// - At-frequency 1: only near matching threshold
// - Over-frequency 2 uses second thresholds
// - At-frequency 2 uses second thresholds
// - Four thresholds, 0 to 400 Hz, reset 0
// - On within 1 %, off 2 % below
// - At-frequency accelerating: off at plus 2 %
// - Decelerating: on plus 1 %, off minus 2 %
// - Relays default to fault and running
//
// The register offsets and the APB interface to the registers were decided locally.
module dsol_top
   import dsol_pkg::*;
#(
   parameter int unsigned CTRL_DIV = CTRL_CYCLES
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   // APB slave
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [7:0]        paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic                   pready_o,
   output logic [31:0]            prdata_o,
   output logic                   pslverr_o,
   // Drive state
   input  wire logic              run_mode_i,
   input  wire logic              dc_brake_i,
   input  wire logic              fault_indication_i,
   input  wire logic              fault_reset_input_i,
   input  wire logic [FREQ_W-1:0] out_freq_i,
   input  wire logic [FREQ_W-1:0] cmd_freq_i,
   input  wire logic [FREQ_W-1:0] max_freq_i,
   // Output stage
   output logic [NUM_OC-1:0]      oc_out_o,
   output logic                   fault_changeover_relay_o,
   output logic                   running_changeover_relay_o,
   output logic                   fault_reset_o
);

   // ---------------------------------------------------------------
   // Control cycle divider
   // ---------------------------------------------------------------
   localparam int unsigned DIV_W = (CTRL_DIV > 1) ? $clog2(CTRL_DIV) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CTRL_DIV - 1);

   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] div_d;
   logic             tick_q;
   wire  logic       div_wrap = (div_q == DIV_LAST);

   assign div_d = div_wrap ? '0 : div_q + DIV_W'(1);

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         div_q  <= div_d;
         tick_q <= div_wrap;
      end
   end

   // ---------------------------------------------------------------
   // APB access decode
   // ---------------------------------------------------------------
   logic        pready_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;

   wire logic access   = psel_i && penable_i;
   wire logic complete = access && pready_q;
   wire logic wr_en    = complete && pwrite_i;
   wire logic hit_oc   = (paddr_i == ADDR_OC_FUNC);
   wire logic hit_rly  = (paddr_i == ADDR_RLY_FUNC);
   wire logic hit_sns  = (paddr_i == ADDR_SENSE);
   wire logic hit_acc  = (paddr_i == ADDR_ACC_TH);
   wire logic hit_dec  = (paddr_i == ADDR_DEC_TH);
   wire logic hit_acc2 = (paddr_i == ADDR_ACC_TH2);
   wire logic hit_dec2 = (paddr_i == ADDR_DEC_TH2);
   wire logic hit_st   = (paddr_i == ADDR_STATUS);
   wire logic mapped   = hit_oc || hit_rly || hit_sns || hit_acc || hit_dec
                         || hit_acc2 || hit_dec2 || hit_st;

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   logic [CODE_W-1:0] oc_code_q [NUM_OC];
   logic [CODE_W-1:0] fault_rly_code_q;
   logic [CODE_W-1:0] run_rly_code_q;
   logic [NUM_OC-1:0] oc_sense_q;
   logic [1:0]        rly_sense_q;
   logic [FREQ_W-1:0] acc_th_q;
   logic [FREQ_W-1:0] dec_th_q;
   logic [FREQ_W-1:0] acc_th2_q;
   logic [FREQ_W-1:0] dec_th2_q;

   // Thresholds saturate at 400.00 Hz
   wire logic [FREQ_W-1:0] wr_freq = pwdata_i[FREQ_W-1:0];
   wire logic [FREQ_W-1:0] th_wr   = (wr_freq > TH_MAX) ? TH_MAX : wr_freq;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_OC; gi++) begin : g_oc_code
         always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
               oc_code_q[gi] <= RST_OC_CODE;
            end else if (wr_en && hit_oc) begin
               oc_code_q[gi] <= pwdata_i[gi*FUNC_STRIDE +: CODE_W];
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         fault_rly_code_q <= RST_FAULT_RLY;
         run_rly_code_q   <= RST_RUN_RLY;
      end else if (wr_en && hit_rly) begin
         fault_rly_code_q <= pwdata_i[0 +: CODE_W];
         run_rly_code_q   <= pwdata_i[FUNC_STRIDE +: CODE_W];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         oc_sense_q  <= RST_SENSE[NUM_OC-1:0];
         rly_sense_q <= RST_SENSE[SENSE_RLY_LSB +: 2];
      end else if (wr_en && hit_sns) begin
         oc_sense_q  <= pwdata_i[NUM_OC-1:0];
         rly_sense_q <= pwdata_i[SENSE_RLY_LSB +: 2];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         acc_th_q  <= RST_TH;
         dec_th_q  <= RST_TH;
         acc_th2_q <= RST_TH;
         dec_th2_q <= RST_TH;
      end else if (wr_en) begin
         if (hit_acc) begin
            acc_th_q <= th_wr;
         end
         if (hit_dec) begin
            dec_th_q <= th_wr;
         end
         if (hit_acc2) begin
            acc_th2_q <= th_wr;
         end
         if (hit_dec2) begin
            dec_th2_q <= th_wr;
         end
      end
   end

   // ---------------------------------------------------------------
   // Hysteresis bands and ramp direction
   // ---------------------------------------------------------------
   localparam int unsigned PROD_W = FREQ_W + 2;

   logic [FREQ_W-1:0] band_on_q;
   logic [FREQ_W-1:0] band_off_q;
   logic [FREQ_W-1:0] prev_freq_q;
   logic              accel_q;
   logic              decel_q;

   wire logic [PROD_W-1:0] prod_on  = PROD_W'(max_freq_i) * PROD_W'(PCT_ON);
   wire logic [PROD_W-1:0] prod_off = PROD_W'(max_freq_i) * PROD_W'(PCT_OFF);
   wire logic [PROD_W-1:0] quot_on  = prod_on / PROD_W'(PCT_DIV);
   wire logic [PROD_W-1:0] quot_off = prod_off / PROD_W'(PCT_DIV);
   wire logic              rising   = out_freq_i > prev_freq_q;
   wire logic              falling  = out_freq_i < prev_freq_q;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         band_on_q   <= '0;
         band_off_q  <= '0;
         prev_freq_q <= '0;
         accel_q     <= 1'b0;
         decel_q     <= 1'b0;
      end else if (tick_q) begin
         band_on_q   <= quot_on[FREQ_W-1:0];
         band_off_q  <= quot_off[FREQ_W-1:0];
         prev_freq_q <= out_freq_i;
         // Direction is kept across steady cycles
         if (rising || falling) begin
            accel_q <= rising;
            decel_q <= falling;
         end
      end
   end

   // ---------------------------------------------------------------
   // Arrival detectors
   // ---------------------------------------------------------------
   localparam dsol_arr_kind_t ARR_KINDS [NUM_ARR] =
      '{ARR_CONST, ARR_OVER, ARR_AT, ARR_OVER, ARR_AT};

   wire logic [FREQ_W-1:0] tgt_acc [NUM_ARR];
   wire logic [FREQ_W-1:0] tgt_dec [NUM_ARR];
   logic [NUM_ARR-1:0]     arr_flag;

   assign tgt_acc[0] = cmd_freq_i;
   assign tgt_dec[0] = cmd_freq_i;
   assign tgt_acc[1] = acc_th_q;
   assign tgt_dec[1] = dec_th_q;
   assign tgt_acc[2] = acc_th_q;
   assign tgt_dec[2] = dec_th_q;
   assign tgt_acc[3] = acc_th2_q;
   assign tgt_dec[3] = dec_th2_q;
   assign tgt_acc[4] = acc_th2_q;
   assign tgt_dec[4] = dec_th2_q;

   generate
      for (gi = 0; gi < NUM_ARR; gi++) begin : g_arr
         dsol_arrival #(
            .KIND (ARR_KINDS[gi])
         ) u_arr (
            .ref_clk_i    (ref_clk_i),
            .rst_n_i      (rst_n_i),
            .tick_i       (tick_q),
            .freq_i       (out_freq_i),
            .target_acc_i (tgt_acc[gi]),
            .target_dec_i (tgt_dec[gi]),
            .band_on_i    (band_on_q),
            .band_off_i   (band_off_q),
            .accel_i      (accel_q),
            .decel_i      (decel_q),
            .flag_o       (arr_flag[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Function selection and contact sense
   // ---------------------------------------------------------------
   wire logic running = run_mode_i || dc_brake_i;

   // Relays carry the running and fault indications only
   function automatic logic dsol_select(input logic [CODE_W-1:0] code,
                                        input logic              is_relay,
                                        input logic              run_ind,
                                        input logic              fault_ind,
                                        input logic [NUM_ARR-1:0] arr);
      case (code)
         CODE_RUN: dsol_select = run_ind;
         CODE_ALM: dsol_select = fault_ind;
         CODE_FA1: dsol_select = !is_relay && arr[0];
         CODE_FA2: dsol_select = !is_relay && arr[1];
         CODE_FA3: dsol_select = !is_relay && arr[2];
         CODE_FA4: dsol_select = !is_relay && arr[3];
         CODE_FA5: dsol_select = !is_relay && arr[4];
         default:  dsol_select = 1'b0;
      endcase
   endfunction

   wire logic [NUM_OC-1:0] oc_ind;
   wire logic [NUM_OC-1:0] oc_pin_d;
   wire logic              fault_rly_ind;
   wire logic              run_rly_ind;

   generate
      for (gi = 0; gi < NUM_OC; gi++) begin : g_oc_sel
         assign oc_ind[gi] = dsol_select(oc_code_q[gi], 1'b0, running,
                                         fault_indication_i, arr_flag);
      end
   endgenerate

   assign fault_rly_ind = dsol_select(fault_rly_code_q, 1'b1, running,
                                      fault_indication_i, arr_flag);
   assign run_rly_ind   = dsol_select(run_rly_code_q, 1'b1, running,
                                      fault_indication_i, arr_flag);
   assign oc_pin_d      = oc_ind ^ oc_sense_q;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         oc_out_o                   <= '0;
         fault_changeover_relay_o   <= 1'b0;
         running_changeover_relay_o <= 1'b0;
         fault_reset_o              <= 1'b0;
      end else begin
         oc_out_o                   <= oc_pin_d;
         fault_changeover_relay_o   <= fault_rly_ind ^ rly_sense_q[0];
         running_changeover_relay_o <= run_rly_ind ^ rly_sense_q[1];
         fault_reset_o              <= fault_reset_input_i;
      end
   end

   // ---------------------------------------------------------------
   // Read data and APB answer
   // ---------------------------------------------------------------
   wire logic [31:0] rd_oc = {3'h0, oc_code_q[3], 3'h0, oc_code_q[2],
                              3'h0, oc_code_q[1], 3'h0, oc_code_q[0]};
   wire logic [31:0] rd_rly = {19'h0, run_rly_code_q, 3'h0, fault_rly_code_q};
   wire logic [31:0] rd_sns = {26'h0, rly_sense_q, oc_sense_q};
   wire logic [31:0] rd_st  = {16'h0, decel_q, accel_q,
                               running_changeover_relay_o, fault_changeover_relay_o,
                               oc_out_o, fault_reset_input_i, fault_indication_i,
                               arr_flag, running};
   wire logic [31:0] rd_mux = hit_oc   ? rd_oc :
                              hit_rly  ? rd_rly :
                              hit_sns  ? rd_sns :
                              hit_acc  ? {16'h0, acc_th_q} :
                              hit_dec  ? {16'h0, dec_th_q} :
                              hit_acc2 ? {16'h0, acc_th2_q} :
                              hit_dec2 ? {16'h0, dec_th2_q} :
                              hit_st   ? rd_st : 32'h0;

   // One wait state: pready rises in the second access cycle
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pready_q  <= 1'b0;
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= access && !pready_q;
         prdata_q  <= (access && !pready_q && !pwrite_i) ? rd_mux : 32'h0;
         pslverr_q <= access && !pready_q && !mapped;
      end
   end

   assign pready_o  = pready_q;
   assign prdata_o  = prdata_q;
   assign pslverr_o = pslverr_q;

endmodule

// >>> rtl/dsol_pkg.sv
package dsol_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int unsigned FREQ_W    = 16;   // Frequency in 0.01 Hz units
   localparam int unsigned CODE_W    = 5;    // Output function code width
   localparam int unsigned NUM_OC    = 4;    // Open-collector outputs
   localparam int unsigned NUM_RLY   = 2;    // Changeover relays
   localparam int unsigned NUM_ARR   = 5;    // Arrival indications

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_OC_FUNC    = 8'h00;
   localparam logic [7:0] ADDR_RLY_FUNC   = 8'h04;
   localparam logic [7:0] ADDR_SENSE      = 8'h08;
   localparam logic [7:0] ADDR_ACC_TH     = 8'h0c;
   localparam logic [7:0] ADDR_DEC_TH     = 8'h10;
   localparam logic [7:0] ADDR_ACC_TH2    = 8'h14;
   localparam logic [7:0] ADDR_DEC_TH2    = 8'h18;
   localparam logic [7:0] ADDR_STATUS     = 8'h1c;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned FUNC_STRIDE    = 8;    // Code n at [8n+4:8n]
   localparam int unsigned SENSE_RLY_LSB  = 4;    // Relay sense bits [5:4]
   localparam int unsigned ST_RUN         = 0;
   localparam int unsigned ST_ARR_LSB     = 1;    // Arrival flags [5:1]
   localparam int unsigned ST_FAULT       = 6;
   localparam int unsigned ST_FRST        = 7;
   localparam int unsigned ST_OC_LSB      = 8;    // OC pins [11:8]
   localparam int unsigned ST_RLY_LSB     = 12;   // Relays [13:12]
   localparam int unsigned ST_ACCEL       = 14;
   localparam int unsigned ST_DECEL       = 15;

   // ---------------------------------------------------------------
   // Reset values and limits
   // ---------------------------------------------------------------
   localparam logic [CODE_W-1:0] CODE_RUN  = 5'h00;
   localparam logic [CODE_W-1:0] CODE_FA1  = 5'h01;
   localparam logic [CODE_W-1:0] CODE_FA2  = 5'h02;
   localparam logic [CODE_W-1:0] CODE_ALM  = 5'h05;
   localparam logic [CODE_W-1:0] CODE_FA3  = 5'h06;
   localparam logic [CODE_W-1:0] CODE_FA4  = 5'h13;
   localparam logic [CODE_W-1:0] CODE_FA5  = 5'h14;
   localparam logic [CODE_W-1:0] RST_OC_CODE      = 5'h00;
   localparam logic [CODE_W-1:0] RST_FAULT_RLY    = 5'h05;
   localparam logic [CODE_W-1:0] RST_RUN_RLY      = 5'h00;
   localparam logic [5:0]        RST_SENSE        = 6'h00;
   localparam logic [FREQ_W-1:0] RST_TH           = 16'h0000;
   localparam logic [FREQ_W-1:0] TH_MAX           = 16'h9c40;  // 400.00 Hz
   localparam int unsigned       PCT_ON           = 1;
   localparam int unsigned       PCT_OFF          = 2;
   localparam int unsigned       PCT_DIV          = 100;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned CTRL_PERIOD_NS = 1000;  // Control cycle
   localparam int unsigned CTRL_CYCLES    = CTRL_PERIOD_NS / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Arrival detector kinds
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ARR_CONST = 2'b00,
      ARR_OVER  = 2'b01,
      ARR_AT    = 2'b10
   } dsol_arr_kind_t;

   // Arithmetic on frequencies, one guard bit; subtraction saturates at zero, addition does not
   function automatic logic [FREQ_W:0] dsol_sub_sat(input logic [FREQ_W-1:0] a,
                                                    input logic [FREQ_W-1:0] b);
      logic [FREQ_W:0] d;
      d = {1'b0, a} - {1'b0, b};
      dsol_sub_sat = d[FREQ_W] ? '0 : d;
   endfunction

   function automatic logic [FREQ_W:0] dsol_add(input logic [FREQ_W-1:0] a,
                                                input logic [FREQ_W-1:0] b);
      dsol_add = {1'b0, a} + {1'b0, b};
   endfunction

endpackage

// >>> rtl/dsol_arrival.sv
module dsol_arrival
   import dsol_pkg::*;
#(
   parameter dsol_arr_kind_t KIND = ARR_CONST
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              tick_i,
   input  wire logic [FREQ_W-1:0] freq_i,
   input  wire logic [FREQ_W-1:0] target_acc_i,
   input  wire logic [FREQ_W-1:0] target_dec_i,
   input  wire logic [FREQ_W-1:0] band_on_i,
   input  wire logic [FREQ_W-1:0] band_off_i,
   input  wire logic              accel_i,
   input  wire logic              decel_i,
   output logic                   flag_o
);

   // ---------------------------------------------------------------
   // Band edges
   // ---------------------------------------------------------------
   wire logic [FREQ_W:0] f_x      = {1'b0, freq_i};
   wire logic [FREQ_W:0] acc_lo1  = dsol_sub_sat(target_acc_i, band_on_i);
   wire logic [FREQ_W:0] acc_hi1  = dsol_add(target_acc_i, band_on_i);
   wire logic [FREQ_W:0] acc_lo2  = dsol_sub_sat(target_acc_i, band_off_i);
   wire logic [FREQ_W:0] acc_hi2  = dsol_add(target_acc_i, band_off_i);
   wire logic [FREQ_W:0] dec_hi1  = dsol_add(target_dec_i, band_on_i);
   wire logic [FREQ_W:0] dec_lo2  = dsol_sub_sat(target_dec_i, band_off_i);

   // Constant speed: on inside +/-1 %, off outside +/-2 %
   wire logic const_set = (f_x >= acc_lo1) && (f_x <= acc_hi1);
   wire logic const_clr = (f_x < acc_lo2) || (f_x > acc_hi2);
   // Over-frequency: on rising past threshold, off falling past lower one
   wire logic over_set  = accel_i && (f_x >= acc_lo1);
   wire logic over_clr  = decel_i && (f_x < dec_lo2);
   // At-frequency windows per direction
   wire logic at_acc    = (f_x >= acc_lo1) && (f_x < acc_hi2);
   wire logic at_dec    = (f_x <= dec_hi1) && (f_x > dec_lo2);

   logic flag_d;
   always_comb begin
      flag_d = flag_o;
      case (KIND)
         ARR_CONST: begin
            if (const_set) begin
               flag_d = 1'b1;
            end else if (const_clr) begin
               flag_d = 1'b0;
            end
         end
         ARR_OVER: begin
            if (over_set) begin
               flag_d = 1'b1;
            end else if (over_clr) begin
               flag_d = 1'b0;
            end
         end
         ARR_AT: begin
            if (accel_i) begin
               flag_d = at_acc;
            end else if (decel_i) begin
               flag_d = at_dec;
            end
         end
         default: flag_d = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         flag_o <= 1'b0;
      end else if (tick_i) begin
         flag_o <= flag_d;
      end
   end

endmodule

// >>> tb/dsol_top_checker.sv
module dsol_top_checker
   import dsol_pkg::*;
#(
   parameter int unsigned CTRL_DIV = 4
) (
   input wire logic              ref_clk_i,
   input wire logic              rst_n_i,
   input wire logic              psel_i,
   input wire logic              penable_i,
   input wire logic              pwrite_i,
   input wire logic [7:0]        paddr_i,
   input wire logic              pready_o,
   input wire logic [31:0]       prdata_o,
   input wire logic              pslverr_o,
   input wire logic              run_mode_i,
   input wire logic              dc_brake_i,
   input wire logic              fault_indication_i,
   input wire logic              fault_reset_input_i,
   input wire logic              fault_reset_o,
   input wire logic [NUM_OC-1:0] oc_out_o,
   input wire logic              fault_changeover_relay_o,
   input wire logic              running_changeover_relay_o
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic [2:0] drv = {run_mode_i, dc_brake_i, fault_indication_i};
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   chk_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   chk_ready_wait: assert property (psel_i && $rose(penable_i) |-> !pready_o ##1 pready_o)
      else $error("ready not in second access cycle");
   chk_err_unmapped: assert property (pready_o
      && (paddr_i > 8'h1c || paddr_i[1:0] != 2'h0) |-> pslverr_o)
      else $error("unmapped address not refused");
   chk_err_mapped: assert property (pready_o
      && paddr_i <= 8'h1c && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
      else $error("mapped address refused");
   chk_idle_data: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
      else $error("read data outside answer");
   chk_reset_copy: assert property ($past(rst_n_i) |-> fault_reset_o == $past(fault_reset_input_i))
      else $error("fault reset pin not a plain copy");
   chk_run_relay_cause: assert property ($past(rst_n_i) && $past(rst_n_i, 2)
      && $changed(running_changeover_relay_o)
      |-> $past(drv) != $past(drv, 2) || $past(pready_o && pwrite_i, 2))
      else $error("running relay changed without cause");
   chk_fault_relay_cause: assert property ($past(rst_n_i) && $past(rst_n_i, 2)
      && $changed(fault_changeover_relay_o)
      |-> $past(drv) != $past(drv, 2) || $past(pready_o && pwrite_i, 2))
      else $error("fault relay changed without cause");
   cov_refused: cover property (pslverr_o);
   cov_run_relay: cover property ($rose(running_changeover_relay_o));
   cov_oc_all: cover property (oc_out_o == 4'hf);
endmodule

bind dsol_top dsol_top_checker #(.CTRL_DIV(CTRL_DIV)) i_dsol_top_checker (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o), .prdata_o(prdata_o),
   .pslverr_o(pslverr_o), .run_mode_i(run_mode_i), .dc_brake_i(dc_brake_i),
   .fault_indication_i(fault_indication_i), .fault_reset_input_i(fault_reset_input_i),
   .fault_reset_o(fault_reset_o), .oc_out_o(oc_out_o),
   .fault_changeover_relay_o(fault_changeover_relay_o),
   .running_changeover_relay_o(running_changeover_relay_o));

// >>> tb/dsol_plc_model.sv
module dsol_plc_model
   import dsol_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic [NUM_OC-1:0] oc_out_i,
   input  wire logic              relay_fault_i,
   input  wire logic              relay_run_i,
   output logic [NUM_OC+1:0]      seen_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Controller input scan: one register stage, no filtering
   always_ff @(posedge ref_clk_i) begin
      seen_o <= {relay_run_i, relay_fault_i, oc_out_i};
   end
endmodule

// >>> tb/tb_dsol_top.sv
module tb_dsol_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dsol_pkg::*;
   localparam int unsigned DIV = 4;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        run_mode = 1'b0;
   logic        dc_brake = 1'b0;
   logic        fault_ind = 1'b0;
   logic        fault_rst = 1'b0;
   logic [15:0] out_freq = 16'h0000;
   logic [15:0] cmd_freq = 16'h1388;
   logic [15:0] max_freq = 16'h2710;
   logic        pready, pslverr, relay_fault, relay_run, fault_rst_q;
   logic [31:0] prdata;
   logic [3:0]  oc_out;
   logic [5:0]  seen;
   int          errors = 0;
   int          checked = 0;
   always #5 clk = ~clk;

   dsol_top #(.CTRL_DIV(DIV)) i_dsol_top (.ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .run_mode_i(run_mode),
      .dc_brake_i(dc_brake), .fault_indication_i(fault_ind), .fault_reset_input_i(fault_rst),
      .out_freq_i(out_freq), .cmd_freq_i(cmd_freq), .max_freq_i(max_freq), .oc_out_o(oc_out),
      .fault_changeover_relay_o(relay_fault), .running_changeover_relay_o(relay_run),
      .fault_reset_o(fault_rst_q));
   dsol_plc_model i_dsol_plc_model (.ref_clk_i(clk), .oc_out_i(oc_out),
      .relay_fault_i(relay_fault), .relay_run_i(relay_run), .seen_o(seen));

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] x,
                     input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      cmp(what, x, r);
      cmp("slverr", 32'(xe), 32'(e));
   endtask
   task automatic t_reset_values();
      rd("oc_func", ADDR_OC_FUNC, 32'h0, 1'b0);
      rd("rly_func", ADDR_RLY_FUNC, 32'h00000005, 1'b0);
      rd("sense", ADDR_SENSE, 32'h0, 1'b0);
      for (int i = 0; i < 4; i++) rd("threshold", ADDR_ACC_TH + 8'(4 * i), 32'h0, 1'b0);
      rd("unmapped", 8'h20, 32'h0, 1'b1);
      wr(ADDR_ACC_TH, 32'h0000ffff);
      rd("saturated", ADDR_ACC_TH, 32'h00009c40, 1'b0);
   endtask
   task automatic t_running();
      run_mode <= 1'b1;
      cyc(4);
      cmp("pins run", 32'h2f, 32'(seen));
      rd("status", ADDR_STATUS, 32'h2f01, 1'b0);
      run_mode <= 1'b0;
      dc_brake <= 1'b1;
      cyc(4);
      cmp("pins brake", 32'h2f, 32'(seen));
      dc_brake <= 1'b0;
      cyc(4);
      cmp("pins stop", 32'h00, 32'(seen));
   endtask
   task automatic t_sense();
      wr(ADDR_SENSE, 32'h25);
      fault_ind <= 1'b1;
      fault_rst <= 1'b1;
      cyc(4);
      cmp("pins inverted", 32'h35, 32'(seen));
      cmp("fault reset", 32'h1, 32'(fault_rst_q));
      run_mode <= 1'b1;
      cyc(4);
      cmp("pins inverted run", 32'h1a, 32'(seen));
      run_mode <= 1'b0;
      fault_ind <= 1'b0;
      fault_rst <= 1'b0;
      wr(ADDR_SENSE, 32'h0);
      cyc(4);
      cmp("pins plain", 32'h00, 32'(seen));
   endtask
   task automatic t_arrival();
      logic [15:0] fl [10] = '{16'h0b86, 16'h0cb2, 16'h0f6e, 16'h1356, 16'h1482,
                               16'h0802, 16'h06d6, 16'h02bc, 16'h0fa0, 16'h10cc};
      logic [3:0]  xl [10] = '{4'h6, 4'h2, 4'ha, 4'hb, 4'ha, 4'he, 4'h8, 4'h0, 4'h1, 4'h0};
      wr(ADDR_ACC_TH, 32'h0bb8);
      wr(ADDR_DEC_TH, 32'h07d0);
      wr(ADDR_ACC_TH2, 32'h0fa0);
      wr(ADDR_DEC_TH2, 32'h03e8);
      wr(ADDR_OC_FUNC, 32'h13060201);
      for (int i = 0; i < 10; i++) begin
         if (i == 8) wr(ADDR_OC_FUNC, 32'h14);
         out_freq <= fl[i];
         cyc(4 * DIV + 4);
         cmp("arrival pins", 32'(xl[i]), 32'(seen[3:0]));
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      cyc(2);
      rst_n <= 1'b1;
      t_reset_values();
      t_running();
      t_sense();
      t_arrival();
      complete_run();
   end
   initial begin
      #50000;
      errors++;
      complete_run();
   end
endmodule
